/* File: include/rrps_pkg.sv */
// Constants, register map and carrier types of the rail ramp and power sequencer.
// Assumes a serial management bus decoder upstream that presents byte accesses.
// How it works
// (RULE1) Trigger bit clears itself when both buck rails reach their targets.
// (RULE2) Writing 1 to trigger ramps both buck rails to stored set-points; 0 does nothing.
// (RULE3) Auto-apply disable at 1: set-point writes start a paced ramp without trigger.
// (RULE4) Step-time code 000b is 160 us per step, each higher code halves it.
// (RULE5) Step-time code 111b applies the new set-point at once.
// (RULE6) Linear regulator set-point is a 6-bit code, bits 5..0, reset 1Fh.
// (RULE7) Delay bit n-1 of first delay register picks 2 ms or 5 ms after strobe n; power-down uses it after strobe n+1.
// (RULE8) Bit 0 of second delay register picks the wait between strobes 9 and 10.
// (RULE9) Multiplier bit 7 at 1 scales every power-down delay by ten.
// (RULE10) Power-up sequencing never uses the multiplier.
// (RULE11) Buck two slot field is bits 7..4, reset 9h, codes 3..10 map to strobes.
// (RULE12) Buck one slot field is bits 3..0, reset 8h, same code mapping.
// (RULE13) Slot codes below 3 or above 10 keep the rail away from the sequencer.
// (RULE14) Pacing and trigger act only on the two buck rails.
// (RULE15) Power-up issues strobes ascending, enabling rails at their slot, then waits.
// (RULE16) Reserved bits read zero and ignore writes.
package rrps_pkg;
	// ==========================================
	// Register offsets
	localparam logic [7:0] ADDR_BUCK1 = 8'h16;
	localparam logic [7:0] ADDR_BUCK2 = 8'h17;
	localparam logic [7:0] ADDR_RAMP = 8'h1A;
	localparam logic [7:0] ADDR_LREG = 8'h1B;
	localparam logic [7:0] ADDR_DLY_LO = 8'h20;
	localparam logic [7:0] ADDR_DLY_HI = 8'h21;
	localparam logic [7:0] ADDR_SLOT = 8'h22;

	// ==========================================
	// Reset values and writable masks
	localparam logic [7:0] RST_BUCK = 8'h99;
	localparam logic [7:0] RST_RAMP = 8'h06;
	localparam logic [7:0] RST_LREG = 8'h1F;
	localparam logic [7:0] RST_DLY_LO = 8'h00;
	localparam logic [7:0] RST_DLY_HI = 8'h00;
	localparam logic [7:0] RST_SLOT = 8'h98;
	localparam logic [7:0] MASK_BUCK = 8'hBF;
	localparam logic [7:0] MASK_RAMP = 8'hC7;
	localparam logic [7:0] MASK_LREG = 8'h3F;
	localparam logic [7:0] MASK_DLY_HI = 8'h81;

	// ==========================================
	// Field positions
	localparam int BIT_TRIGGER = 7;
	localparam int BIT_AUTO_DIS = 6;
	localparam int BIT_DN_MULT = 7;
	localparam logic [2:0] STEP_IMMEDIATE = 3'h7;
	localparam logic [3:0] SLOT_FIRST = 4'h3;
	localparam logic [3:0] SLOT_LAST = 4'hA;
	localparam logic [3:0] STROBE_COUNT = 4'hA;

	// ==========================================
	// Timing
	localparam int CLK_MHZ = 125;
	localparam int STEP_BASE_NS = 160000;
	localparam int DLY_SHORT_MS = 2;
	localparam int DLY_LONG_MS = 5;
	localparam int DN_FACTOR = 10;
	localparam int STEP_BASE_CYC = (STEP_BASE_NS * CLK_MHZ + 999) / 1000;
	localparam int DLY_SHORT_CYC = DLY_SHORT_MS * CLK_MHZ * 1000;
	localparam int DLY_LONG_CYC = DLY_LONG_MS * CLK_MHZ * 1000;

	// ==========================================
	// Carrier types
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rrps_reg_req_s;

	typedef enum logic [2:0] {
		SEQ_IDLE = 3'b001,
		SEQ_UP = 3'b010,
		SEQ_DOWN = 3'b100
	} rrps_seq_e;
endpackage : rrps_pkg

/* File: design/rrps_top.sv */
// Rail ramp pacing, linear regulator set-point and ten-strobe power sequencer.
// Assumes register accesses and power requests come from logic on clk.
// Power requests are honoured only while seq_busy is low.
// Rail enables and codes feed the converters; their analog settling is not modelled here.
`timescale 1ns/10ps
`default_nettype none
module rrps_top #(
	parameter int STEP_BASE = rrps_pkg::STEP_BASE_CYC,
	parameter int DLY_SHORT = rrps_pkg::DLY_SHORT_CYC,
	parameter int DLY_LONG = rrps_pkg::DLY_LONG_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Register access
	input wire rrps_pkg::rrps_reg_req_s req,
	output logic [7:0] rdata_q,
	output logic rvalid_q,
	// Power requests, one-cycle pulses
	input wire logic pwr_up_req,
	input wire logic pwr_dn_req,
	// Rail controls
	output logic [5:0] buck_rail_one_code_q,
	output logic [5:0] buck_rail_two_code_q,
	output logic [5:0] linear_reg_setpoint,
	output logic buck_rail_one_en_q,
	output logic buck_rail_two_en_q,
	output logic strobe_pulse_q,
	output logic [3:0] strobe_num_q,
	output logic seq_busy
);
	import rrps_pkg::*;

	// Delay timer, wide enough for ten times the long delay at the default clock
	localparam int TMR_W = 24;
	localparam logic [TMR_W-1:0] T_SHORT = TMR_W'(DLY_SHORT);
	localparam logic [TMR_W-1:0] T_LONG = TMR_W'(DLY_LONG);
	localparam logic [TMR_W-1:0] T_SHORT_DN = TMR_W'(DLY_SHORT * DN_FACTOR);
	localparam logic [TMR_W-1:0] T_LONG_DN = TMR_W'(DLY_LONG * DN_FACTOR);

	// ==========================================
	// Register file
	// Reserved bits are masked on write, so they always read zero
	// Start pulse lags the write by one edge, so targets come from updated registers
	// Trigger bit stays set while a ramp runs and clears one edge after it ends
	logic [7:0] buck1_q, buck1_d, buck2_q, buck2_d, ramp_q, ramp_d;
	logic [7:0] lreg_q, lreg_d, dly_lo_q, dly_lo_d, dly_hi_q, dly_hi_d, slot_q, slot_d;
	logic start_q, start_d;
	logic ramp_done;

	// Register writes, trigger set and self-clear
	always_comb begin
		buck1_d = buck1_q;
		buck2_d = buck2_q;
		ramp_d = ramp_q;
		lreg_d = lreg_q;
		dly_lo_d = dly_lo_q;
		dly_hi_d = dly_hi_q;
		slot_d = slot_q;
		start_d = 1'b0;
		// Self-clear yields to a start in the same cycle, so a restarted ramp keeps its trigger
		if (ramp_done && !start_q) begin
			ramp_d[BIT_TRIGGER] = 1'b0; // see (RULE1)
		end
		if (req.wr) begin
			unique case (req.addr)
				ADDR_BUCK1: begin
					buck1_d = req.wdata & MASK_BUCK;
					start_d = ramp_q[BIT_AUTO_DIS]; // see (RULE3)
				end
				ADDR_BUCK2: begin
					buck2_d = req.wdata & MASK_BUCK;
					start_d = ramp_q[BIT_AUTO_DIS]; // see (RULE3)
				end
				ADDR_RAMP: begin
					// Set wins over the self-clear; writing 0 leaves a running ramp alone
					ramp_d = (req.wdata & MASK_RAMP) | {ramp_d[BIT_TRIGGER], 7'h00}; // see (RULE2) (RULE16)
					start_d = req.wdata[BIT_TRIGGER]; // see (RULE2)
				end
				ADDR_LREG: lreg_d = req.wdata & MASK_LREG; // see (RULE6) (RULE16)
				ADDR_DLY_LO: dly_lo_d = req.wdata; // see (RULE7)
				ADDR_DLY_HI: dly_hi_d = req.wdata & MASK_DLY_HI; // see (RULE8) (RULE9) (RULE16)
				ADDR_SLOT: slot_d = req.wdata; // see (RULE11) (RULE12)
				default: begin
				end
			endcase
		end
	end

	// Register stage of the register file
	always_ff @(posedge clk) begin
		if (srst) begin
			buck1_q <= RST_BUCK;
			buck2_q <= RST_BUCK;
			ramp_q <= RST_RAMP;
			lreg_q <= RST_LREG;
			dly_lo_q <= RST_DLY_LO;
			dly_hi_q <= RST_DLY_HI;
			slot_q <= RST_SLOT;
			start_q <= 1'b0;
		end else begin
			buck1_q <= buck1_d;
			buck2_q <= buck2_d;
			ramp_q <= ramp_d;
			lreg_q <= lreg_d;
			dly_lo_q <= dly_lo_d;
			dly_hi_q <= dly_hi_d;
			slot_q <= slot_d;
			start_q <= start_d;
		end
	end

	assign linear_reg_setpoint = lreg_q[5:0]; // see (RULE6)

	// ==========================================
	// Read port
	// Read data is registered and holds until the next read strobe
	// A late host can still pick it up after rvalid_q has dropped
	logic [7:0] rdata_d;

	// Unmapped addresses read zero
	always_comb begin
		unique case (req.addr)
			ADDR_BUCK1: rdata_d = buck1_q;
			ADDR_BUCK2: rdata_d = buck2_q;
			ADDR_RAMP: rdata_d = ramp_q;
			ADDR_LREG: rdata_d = lreg_q;
			ADDR_DLY_LO: rdata_d = dly_lo_q;
			ADDR_DLY_HI: rdata_d = dly_hi_q;
			ADDR_SLOT: rdata_d = slot_q;
			default: rdata_d = 8'h00;
		endcase
	end

	// Capture read data on the read strobe
	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			rdata_q <= req.rd ? rdata_d : rdata_q;
			rvalid_q <= req.rd;
		end
	end

	// ==========================================
	// Buck rail ramp engine, only the two buck rails
	// Both rails move one code per step period, each toward its own target
	// Targets latch at start; set-point writes mid-ramp wait for the next start
	// Code 7 skips pacing, leaving the slew to the converter loop
	// Other rails never pass through here and change at once
	logic [5:0] tgt1_q, tgt1_d, tgt2_q, tgt2_d, code1_d, code2_d;
	logic ramping_q, ramping_d;
	logic [15:0] step_tmr_q, step_tmr_d, step_len;
	logic [2:0] step_sel;

	assign step_sel = ramp_q[2:0];
	// Cycles per code step, rounded up
	// Rounding up keeps fast codes from stepping quicker than selected
	assign step_len = 16'((STEP_BASE + (1 << step_sel) - 1) >> step_sel); // see (RULE4)
	// Done once both rails sit on their targets
	assign ramp_done = ramping_q && (buck_rail_one_code_q == tgt1_q) && (buck_rail_two_code_q == tgt2_q);

	// Step both rails one code toward target per step period
	always_comb begin
		tgt1_d = tgt1_q;
		tgt2_d = tgt2_q;
		code1_d = buck_rail_one_code_q;
		code2_d = buck_rail_two_code_q;
		ramping_d = ramping_q && !ramp_done; // see (RULE1)
		step_tmr_d = step_tmr_q;
		if (start_q) begin
			tgt1_d = buck1_q[5:0]; // see (RULE2) (RULE14)
			tgt2_d = buck2_q[5:0];
			ramping_d = 1'b1;
			step_tmr_d = step_len;
		end else if (ramping_q && !ramp_done) begin
			if (step_sel == STEP_IMMEDIATE) begin
				code1_d = tgt1_q; // see (RULE5)
				code2_d = tgt2_q;
			end else if (step_tmr_q <= 16'h0001) begin
				step_tmr_d = step_len; // see (RULE4)
				if (code1_d < tgt1_q) code1_d = code1_d + 6'h01;
				else if (code1_d > tgt1_q) code1_d = code1_d - 6'h01;
				if (code2_d < tgt2_q) code2_d = code2_d + 6'h01;
				else if (code2_d > tgt2_q) code2_d = code2_d - 6'h01;
			end else begin
				step_tmr_d = step_tmr_q - 16'h0001;
			end
		end
	end

	// Register stage of the ramp engine
	always_ff @(posedge clk) begin
		if (srst) begin
			tgt1_q <= RST_BUCK[5:0];
			tgt2_q <= RST_BUCK[5:0];
			buck_rail_one_code_q <= RST_BUCK[5:0];
			buck_rail_two_code_q <= RST_BUCK[5:0];
			ramping_q <= 1'b0;
			step_tmr_q <= 16'h0000;
		end else begin
			tgt1_q <= tgt1_d;
			tgt2_q <= tgt2_d;
			buck_rail_one_code_q <= code1_d;
			buck_rail_two_code_q <= code2_d;
			ramping_q <= ramping_d;
			step_tmr_q <= step_tmr_d;
		end
	end

	// ==========================================
	// Power sequencer
	// Strobes run 1 to 10 going up and 10 to 1 going down
	// First strobe one cycle after the request is taken, later ones after their delay
	// Requests while busy are dropped; the host waits for seq_busy to fall
	// Rails with a slot outside 3 to 10 keep their enable untouched
	rrps_seq_e state_q, state_d;
	logic [3:0] strobe_d, next_num, dly_idx;
	logic [TMR_W-1:0] tmr_q, tmr_d;
	logic [8:0] dly_bits;
	logic en1_d, en2_d, pulse_d, dly_long, dn;
	logic [3:0] slot1, slot2;

	assign slot1 = slot_q[3:0];
	assign slot2 = slot_q[7:4];
	assign dly_bits = {dly_hi_q[0], dly_lo_q}; // see (RULE7) (RULE8)
	assign dn = (state_q == SEQ_DOWN);
	assign next_num = dn ? strobe_num_q - 4'h1 : strobe_num_q + 4'h1;
	// Wait after strobe n going up, or before strobe n-1 going down
	assign dly_idx = dn ? next_num - 4'h1 : next_num;
	// Delay bit for the coming wait; indices outside 1..9 belong to a run's last strobe
	always_comb begin
		dly_long = 1'b0;
		if (dly_idx >= 4'h1 && dly_idx <= 4'h9) begin
			dly_long = dly_bits[dly_idx - 4'h1];
		end
	end
	assign seq_busy = (state_q != SEQ_IDLE);

	// Walk the strobes, one per delay
	always_comb begin
		state_d = state_q;
		strobe_d = strobe_num_q;
		tmr_d = tmr_q;
		en1_d = buck_rail_one_en_q;
		en2_d = buck_rail_two_en_q;
		pulse_d = 1'b0;
		unique case (state_q)
			SEQ_IDLE: begin
				// Power-up wins when both requests come together
				if (pwr_up_req) begin
					state_d = SEQ_UP;
					strobe_d = 4'h0;
					tmr_d = '0;
				end else if (pwr_dn_req) begin
					state_d = SEQ_DOWN;
					strobe_d = STROBE_COUNT + 4'h1;
					tmr_d = '0;
				end
			end
			SEQ_UP, SEQ_DOWN: begin
				// Count the wait down, then issue the next strobe
				if (tmr_q != '0) begin
					tmr_d = tmr_q - TMR_W'(1);
				end else begin
					pulse_d = 1'b1;
					strobe_d = next_num; // see (RULE15)
					// Out-of-range slots never match a strobe
					if (slot1 >= SLOT_FIRST && slot1 <= SLOT_LAST && slot1 == next_num) en1_d = !dn; // see (RULE12) (RULE13) (RULE15)
					if (slot2 >= SLOT_FIRST && slot2 <= SLOT_LAST && slot2 == next_num) en2_d = !dn; // see (RULE11) (RULE13)
					if (next_num == (dn ? 4'h1 : STROBE_COUNT)) begin
						state_d = SEQ_IDLE;
					end else if (dn && dly_hi_q[BIT_DN_MULT]) begin
						tmr_d = (dly_long ? T_LONG_DN : T_SHORT_DN) - TMR_W'(1); // see (RULE9)
					end else begin
						tmr_d = (dly_long ? T_LONG : T_SHORT) - TMR_W'(1); // see (RULE7) (RULE10)
					end
				end
			end
		endcase
	end

	// Register stage of the sequencer
	always_ff @(posedge clk) begin
		if (srst) begin
			state_q <= SEQ_IDLE;
			strobe_num_q <= 4'h0;
			tmr_q <= '0;
			buck_rail_one_en_q <= 1'b0;
			buck_rail_two_en_q <= 1'b0;
			strobe_pulse_q <= 1'b0;
		end else begin
			state_q <= state_d;
			strobe_num_q <= strobe_d;
			tmr_q <= tmr_d;
			buck_rail_one_en_q <= en1_d;
			buck_rail_two_en_q <= en2_d;
			strobe_pulse_q <= pulse_d;
		end
	end
endmodule : rrps_top
`default_nettype wire

/* File: bench/rrps_monitor.sv */
// Port checker for the ramp and sequencer block.
// Assumes the block runs on one clock with synchronous reset.
`timescale 1ns/10ps
`default_nettype none
module rrps_monitor (
	// Clock and inputs
	input wire logic clk,
	input wire logic srst,
	input wire rrps_pkg::rrps_reg_req_s req,
	input wire logic pwr_up_req,
	input wire logic pwr_dn_req,
	// Watched outputs
	input wire logic rvalid_q,
	input wire logic [5:0] linear_reg_setpoint,
	input wire logic buck_rail_one_en_q,
	input wire logic buck_rail_two_en_q,
	input wire logic strobe_pulse_q,
	input wire logic [3:0] strobe_num_q,
	input wire logic seq_busy
);
	import rrps_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// ==========================================
	// First strobe two edges after an accepted request
	sequence s_first(logic [3:0] n);
		##2 (strobe_pulse_q && strobe_num_q == n);
	endsequence
	a_read_valid: assert property (req.rd |=> rvalid_q) else $error("read not answered");
	a_up_start: assert property (pwr_up_req && !seq_busy |-> s_first(4'h1))
		else $error("power-up did not start at strobe 1");
	a_down_start: assert property (pwr_dn_req && !pwr_up_req && !seq_busy |-> s_first(STROBE_COUNT))
		else $error("power-down did not start at strobe 10");
	a_busy_start: assert property (pwr_up_req && !seq_busy |=> seq_busy) else $error("busy not raised");
	a_strobe_gap: assert property (strobe_pulse_q && seq_busy |=> !strobe_pulse_q [*8])
		else $error("strobes too close");
	a_lreg_cause: assert property ($changed(linear_reg_setpoint) |->
		$past(req.wr) && $past(req.addr) == ADDR_LREG) else $error("set-point moved without write");
	a_lreg_value: assert property (req.wr && req.addr == ADDR_LREG |=>
		{2'h0, linear_reg_setpoint} == ($past(req.wdata) & MASK_LREG)) else $error("set-point wrong");
	a_one_enable: assert property ($changed(buck_rail_one_en_q) |-> strobe_pulse_q)
		else $error("rail one enable off strobe");
	a_two_enable: assert property ($changed(buck_rail_two_en_q) |-> strobe_pulse_q)
		else $error("rail two enable off strobe");
endmodule : rrps_monitor
bind rrps_top rrps_monitor u_mon (.clk(clk), .srst(srst), .req(req), .pwr_up_req(pwr_up_req),
	.pwr_dn_req(pwr_dn_req), .rvalid_q(rvalid_q), .linear_reg_setpoint(linear_reg_setpoint),
	.buck_rail_one_en_q(buck_rail_one_en_q), .buck_rail_two_en_q(buck_rail_two_en_q),
	.strobe_pulse_q(strobe_pulse_q), .strobe_num_q(strobe_num_q), .seq_busy(seq_busy));
`default_nettype wire

/* File: bench/rrps_host.sv */
// Host model issuing byte register accesses.
// Assumes requests are taken on the edge after they are driven.
`timescale 1ns/10ps
`default_nettype none
module rrps_host (
	// Clock and read return
	input wire logic clk,
	input wire logic [7:0] rdata_q,
	// Request to the device
	output var rrps_pkg::rrps_reg_req_s req
);
	import rrps_pkg::*;
	initial req = '0;
	// Write held one edge, then released with inverted payload
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) req <= '{1'b1, 1'b0, a, d};
		@(posedge clk) req <= '{1'b0, 1'b0, ~a, ~d};
	endtask : wr
	// Read, data taken two cycles after the request edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk) req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk) req <= '{1'b0, 1'b0, ~a, 8'hFF};
		@(posedge clk) #1 d = rdata_q;
	endtask : rd
endmodule : rrps_host
`default_nettype wire

/* File: bench/rrps_bench.sv */
// Self-checking bench: registers, ramp pacing and strobe sequencing.
// Assumes shortened counts: step base 64, delays 20 and 50 cycles.
`timescale 1ns/10ps
`default_nettype none
module rrps_bench;
	import rrps_pkg::*;
	localparam int SH = 20;
	localparam int LG = 50;
	localparam logic [63:0] TA = {8'h30, ADDR_SLOT, ADDR_DLY_HI, ADDR_DLY_LO, ADDR_LREG, ADDR_RAMP, ADDR_BUCK2, ADDR_BUCK1};
	localparam logic [63:0] TR = {8'h00, RST_SLOT, RST_DLY_HI, RST_DLY_LO, RST_LREG, RST_RAMP, RST_BUCK, RST_BUCK};
	localparam logic [63:0] TM = {8'h00, 8'hFF, MASK_DLY_HI, 8'hFF, MASK_LREG, MASK_RAMP, MASK_BUCK, MASK_BUCK};
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic pwr_up_req = 1'b0;
	logic pwr_dn_req = 1'b0;
	rrps_reg_req_s req;
	logic rvalid_q, e1, e2, e1x, e2x, pulse, busy;
	logic [7:0] rdata_q, seed, dl, dh, sl, w;
	logic [5:0] c1, c2, lreg, cur;
	logic [3:0] num;
	int num_errors = 0;
	int num_checks = 0;
	int k;
	rrps_top #(.STEP_BASE(64), .DLY_SHORT(SH), .DLY_LONG(LG)) DUT (.clk(clk), .srst(srst), .req(req),
		.rdata_q(rdata_q), .rvalid_q(rvalid_q), .pwr_up_req(pwr_up_req), .pwr_dn_req(pwr_dn_req),
		.buck_rail_one_code_q(c1), .buck_rail_two_code_q(c2), .linear_reg_setpoint(lreg),
		.buck_rail_one_en_q(e1), .buck_rail_two_en_q(e2), .strobe_pulse_q(pulse), .strobe_num_q(num),
		.seq_busy(busy));
	rrps_host host (.clk(clk), .rdata_q(rdata_q), .req(req));
	// Clock
	initial forever #4 clk = ~clk;
	// ==========================================
	// Helpers
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	// Cycles from trigger write to target code
	function automatic int tcyc(input logic [2:0] c, input logic [5:0] a, input logic [5:0] b);
		return c == 3'h7 ? 3 : 2 + (a > b ? a - b : b - a) * ((64 + (1 << c) - 1) >> c);
	endfunction : tcyc
	// Cycles waited before strobe k of a run
	function automatic int gap(input int k, input logic up);
		logic [8:0] d;
		d = {dh[0], dl};
		if (k == 0)
			return 1;
		return (d[up ? k - 1 : 9 - k] ? LG : SH) * (!up && dh[7] ? 10 : 1) - 1;
	endfunction : gap
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		host.rd(a, d);
		chk(d, e);
	endtask : rdchk
	// Wait for a rail code, which must land within a few cycles of exp
	task automatic ramp(input logic two, input logic [5:0] e, input int exp);
		int n;
		for (n = 0; n < exp + 3 && (two ? c2 : c1) !== e; n++)
			tick(1);
		chk(n >= exp - 2 && n < exp + 3, 1'b1);
	endtask : ramp
	// One sequencer run, checking number, gap, enables and busy
	task automatic seq(input logic up);
		int g;
		int j;
		@(posedge clk) {pwr_up_req, pwr_dn_req} <= {up, !up};
		@(posedge clk) {pwr_up_req, pwr_dn_req} <= 2'b00;
		for (j = 0; j < 10; j++) begin
			for (g = 0; g < 700 && pulse !== 1'b1; g++)
				tick(1);
			if (sl[3:0] >= SLOT_FIRST && sl[3:0] <= SLOT_LAST && sl[3:0] == (up ? j + 1 : 10 - j))
				e1x = up;
			if (sl[7:4] >= SLOT_FIRST && sl[7:4] <= SLOT_LAST && sl[7:4] == (up ? j + 1 : 10 - j))
				e2x = up;
			chk(num, up ? j + 1 : 10 - j);
			chk(g, gap(j, up));
			chk({e2, e1, busy}, {e2x, e1x, j < 9});
			tick(1);
		end
	endtask : seq
	task automatic summarize;
		if (num_errors == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : summarize
	// ==========================================
	// Main sequence
	initial begin
		seed = 8'h05;
		{e1x, e2x} = 2'b00;
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		// Reset values, then random writes through the masks
		for (k = 0; k < 8; k++) begin
			rdchk(TA[k*8 +: 8], TR[k*8 +: 8]);
			seed = lfsr(seed);
			w = TA[k*8 +: 8] == ADDR_RAMP ? seed & 8'h7F : seed;
			host.wr(TA[k*8 +: 8], w);
			rdchk(TA[k*8 +: 8], w & TM[k*8 +: 8]);
		end
		// No auto-apply: codes hold until the trigger
		host.wr(ADDR_RAMP, 8'h06);
		host.wr(ADDR_BUCK1, 8'h1C);
		host.wr(ADDR_BUCK2, 8'h1C);
		tick(10);
		chk(c1, 6'h19);
		host.wr(ADDR_RAMP, 8'h80);
		rdchk(ADDR_RAMP, 8'h80);
		ramp(1'b0, 6'h1C, tcyc(3'h0, 6'h19, 6'h1C) - 3);
		cur = 6'h1C;
		// Every step-time code on rail two, random targets
		for (k = 0; k < 8; k++) begin
			seed = lfsr(seed);
			if (seed[5:0] == cur)
				seed[0] = ~seed[0];
			host.wr(ADDR_BUCK2, seed);
			host.wr(ADDR_RAMP, {5'h10, k[2:0]});
			ramp(1'b1, seed[5:0], tcyc(k[2:0], cur, seed[5:0]));
			cur = seed[5:0];
			tick(3);
			rdchk(ADDR_RAMP, {5'h00, k[2:0]});
		end
		// Auto-apply on set-point write
		host.wr(ADDR_RAMP, 8'h47);
		host.wr(ADDR_BUCK1, 8'h05);
		ramp(1'b0, 6'h05, 3);
		// Out-of-range slots up, boundary slots up, then scaled down
		for (k = 0; k < 3; k++) begin
			seed = lfsr(seed);
			dl = seed;
			dh = {1'b1, 6'h00, seed[3]};
			sl = k == 0 ? 8'hB2 : 8'hA3;
			host.wr(ADDR_DLY_LO, dl);
			host.wr(ADDR_DLY_HI, dh);
			host.wr(ADDR_SLOT, sl);
			seq(k != 2);
		end
		summarize();
	end
endmodule : rrps_bench
`default_nettype wire
